// ---- verilog/dvo_top.sv ----
/*
 * dvo_top: digital output logic for two valve outputs.
 * assumes enable, override and fault levels come already resolved from the
 * input routing logic, all synchronous to mclk_i; registers are reached over
 * a plain port with read data one cycle after the read strobe.
 */
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
module dvo_top
    import dvo_pkg::*;
#(
    parameter int MS_CYC = MS_CYCLES // shorten in simulation
)
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic [NUM_CH-1:0][15:0] ctrl_local_i,
    input wire logic [NUM_CH-1:0] ctrl_fault_i,
    input wire logic [NUM_CH-1:0] enable_ok_i,
    input wire logic [NUM_CH-1:0] enable_fault_i,
    input wire logic [NUM_CH-1:0] override_on_i,
    input wire logic [NUM_CH-1:0] override_fault_i,
    output logic [NUM_CH-1:0] drive_o,
    output logic [NUM_CH-1:0][15:0] current_cmd_o,
    output logic [NUM_CH-1:0] output_feedback_value_o
);
    // ------------------------------------------------------------
    // configuration registers, one entry per channel
    // ------------------------------------------------------------
    logic [15:0] otype_q [NUM_CH];   // output_type_select
    logic [7:0] csrc_q [NUM_CH];     // control_source_select
    logic [1:0] pol_q [NUM_CH];      // polarity selection
    logic fmode_q [NUM_CH];          // fault reaction selection
    logic fstate_q [NUM_CH];         // fault preset state
    logic [15:0] busval_q [NUM_CH];  // bus-commanded digital state
    logic [15:0] boosti_q [NUM_CH];  // boost current
    logic [15:0] holdi_q [NUM_CH];   // hold current
    logic [15:0] boostt_q [NUM_CH];  // boost time in ms
    logic [15:0] blinkt_q [NUM_CH];  // blink period in ms

    // ------------------------------------------------------------
    // channel state
    // ------------------------------------------------------------
    logic [NUM_CH-1:0] logic_q;      // logic state
    logic [NUM_CH-1:0] logic_d;
    logic [NUM_CH-1:0] drive_d;      // next drive state
    logic [NUM_CH-1:0] latch_q;      // latched polarity memory
    logic [NUM_CH-1:0] latch_d;
    logic [NUM_CH-1:0] boost_q;      // boost phase active
    logic [NUM_CH-1:0] boost_d;
    logic [NUM_CH-1:0] logic_rise;   // logic state just turned on
    logic [NUM_CH-1:0] drive_rise;   // drive state just turned on
    logic [NUM_CH-1:0] tmr_tick;     // channel timer period done
    logic [NUM_CH-1:0] tmr_restart;
    logic [NUM_CH-1:0] is_dig;       // digital type selected
    logic [NUM_CH-1:0] is_boost;     // boost-and-hold type selected
    logic [NUM_CH-1:0] in_fault;     // any input reports an error
    logic [NUM_CH-1:0] inhibit;      // override true or enable off
    logic [1:0] eff_pol [NUM_CH];    // polarity after mode folding
    logic [15:0] ctrl_val [NUM_CH];  // selected control value
    logic [15:0] tmr_period [NUM_CH];

    // ------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------
    logic wr_ch;           // channel picked by the address
    logic [5:0] wr_off;    // offset within the channel window
    logic addr_in_map;     // address lands in one of the channel windows

    assign wr_ch = reg_addr_i[6];
    assign wr_off = reg_addr_i[5:0];
    assign addr_in_map = (reg_addr_i[7] == 1'b0);

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int c = 0; c < NUM_CH; c++)
            begin
                otype_q[c] <= OTYPE_RST;
                csrc_q[c] <= CSRC_RST;
                pol_q[c] <= POL_RST;
                fmode_q[c] <= FMODE_RST;
                fstate_q[c] <= FSTATE_RST;
                busval_q[c] <= 16'h0000;
                boosti_q[c] <= BOOSTI_RST;
                holdi_q[c] <= HOLDI_RST;
                boostt_q[c] <= BOOSTT_RST;
                blinkt_q[c] <= BLINKT_RST;
            end
        end
        else if (reg_wr_i && addr_in_map)
        begin
            // unmapped offsets inside a window are ignored
            case (wr_off)
                REG_OTYPE: otype_q[wr_ch] <= reg_wdata_i[15:0];
                REG_CSRC: csrc_q[wr_ch] <= reg_wdata_i[7:0];
                REG_POL: pol_q[wr_ch] <= reg_wdata_i[1:0];
                REG_FMODE: fmode_q[wr_ch] <= reg_wdata_i[0];
                REG_FSTATE: fstate_q[wr_ch] <= reg_wdata_i[0];
                REG_BUSVAL: busval_q[wr_ch] <= reg_wdata_i[15:0];
                REG_BOOSTI: boosti_q[wr_ch] <= reg_wdata_i[15:0];
                REG_HOLDI: holdi_q[wr_ch] <= reg_wdata_i[15:0];
                REG_BOOSTT: boostt_q[wr_ch] <= reg_wdata_i[15:0];
                REG_BLINKT: blinkt_q[wr_ch] <= reg_wdata_i[15:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // register reads: data stands only in the cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            reg_rdata_o <= 32'h0000_0000;
        else if (reg_rd_i && addr_in_map)
        begin
            case (wr_off)
                REG_OTYPE: reg_rdata_o <= {16'h0000, otype_q[wr_ch]};
                REG_CSRC: reg_rdata_o <= {24'h00_0000, csrc_q[wr_ch]};
                REG_POL: reg_rdata_o <= {30'h0000_0000, pol_q[wr_ch]};
                REG_FMODE: reg_rdata_o <= {31'h0000_0000, fmode_q[wr_ch]};
                REG_FSTATE: reg_rdata_o <= {31'h0000_0000, fstate_q[wr_ch]};
                REG_BUSVAL: reg_rdata_o <= {16'h0000, busval_q[wr_ch]};
                REG_BOOSTI: reg_rdata_o <= {16'h0000, boosti_q[wr_ch]};
                REG_HOLDI: reg_rdata_o <= {16'h0000, holdi_q[wr_ch]};
                REG_BOOSTT: reg_rdata_o <= {16'h0000, boostt_q[wr_ch]};
                REG_BLINKT: reg_rdata_o <= {16'h0000, blinkt_q[wr_ch]};
                // live state: fault, boost, drive, logic
                REG_STATUS: reg_rdata_o <= {28'h000_0000, in_fault[wr_ch],
                                            boost_q[wr_ch], drive_o[wr_ch],
                                            logic_q[wr_ch]};
                default: reg_rdata_o <= 32'h0000_0000;
            endcase
        end
        else
            reg_rdata_o <= 32'h0000_0000; // unmapped or idle reads give zero
    end

    // ------------------------------------------------------------
    // per-channel edge detectors and shared channel timer
    // ------------------------------------------------------------
    // the one timer serves blink or boost, never both, which is why
    // blinking is folded away in boost-and-hold mode
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch
        dvo_rise u_logic_rise (
            .mclk_i(mclk_i),
            .rst_i(rst_i),
            .d_i(logic_q[g]),
            .rise_o(logic_rise[g])
        );
        dvo_rise u_drive_rise (
            .mclk_i(mclk_i),
            .rst_i(rst_i),
            .d_i(drive_o[g]),
            .rise_o(drive_rise[g])
        );
        dvo_ms_timer #(.MS_CYC(MS_CYC)) u_timer (
            .mclk_i(mclk_i),
            .rst_i(rst_i),
            .restart_i(tmr_restart[g]),
            .period_ms_i(tmr_period[g]),
            .tick_o(tmr_tick[g])
        );
    end

    // ------------------------------------------------------------
    // input qualification and control selection
    // ------------------------------------------------------------
    always_comb
    begin
        for (int c = 0; c < NUM_CH; c++)
        begin
            is_boost[c] = (otype_q[c] == OTYPE_BOOST);
            is_dig[c] = (otype_q[c] == OTYPE_ONOFF) || is_boost[c];
            // an error on any of the three inputs starts the fault reaction
            in_fault[c] = ctrl_fault_i[c] | enable_fault_i[c]
                          | override_fault_i[c];
            // same priority as the analog path: override, then enable
            inhibit[c] = override_on_i[c] | ~enable_ok_i[c];
            if (csrc_q[c] == CSRC_BUS)
                ctrl_val[c] = busval_q[c];
            else if (csrc_q[c] == CSRC_UNUSED)
                ctrl_val[c] = 16'h0000;    // unused source reads as off
            else
                ctrl_val[c] = ctrl_local_i[c];
            if (is_boost[c] && pol_q[c] == POL_BLINK)
                eff_pol[c] = POL_NORMAL;
            else
                eff_pol[c] = pol_q[c];
            // timer follows drive in boost mode, logic in blink mode
            tmr_restart[c] = is_boost[c] ? drive_rise[c] : logic_rise[c];
            tmr_period[c] = is_boost[c] ? boostt_q[c] : blinkt_q[c];
        end
    end

    // ------------------------------------------------------------
    // logic state and drive state next values
    // ------------------------------------------------------------
    always_comb
    begin
        for (int c = 0; c < NUM_CH; c++)
        begin
            logic_d[c] = 1'b0;
            latch_d[c] = latch_q[c];
            drive_d[c] = 1'b0;
            if (!is_dig[c])
            begin
                // other output types hold logic and drive state off here
                logic_d[c] = 1'b0;
                drive_d[c] = 1'b0;
            end
            else if (in_fault[c])
            begin
                logic_d[c] = logic_q[c];
                if (fmode_q[c] == FMODE_PRESET)
                    drive_d[c] = fstate_q[c];
                else
                    drive_d[c] = drive_o[c];
            end
            else if (inhibit[c])
            begin
                logic_d[c] = 1'b0;
                drive_d[c] = 1'b0;
            end
            else
            begin
                // control drives the channel only on this path
                logic_d[c] = (ctrl_val[c] != 16'h0000);
                case (eff_pol[c])
                    POL_NORMAL: drive_d[c] = logic_q[c];
                    POL_INVERSE: drive_d[c] = ~logic_q[c];
                    POL_LATCHED:
                    begin
                        // only the off-to-on edge counts
                        latch_d[c] = latch_q[c] ^ logic_rise[c];
                        drive_d[c] = latch_d[c];
                    end
                    POL_BLINK:
                    begin
                        if (!logic_q[c])
                            drive_d[c] = 1'b0;
                        else if (logic_rise[c])
                            drive_d[c] = 1'b1;
                        else if (tmr_tick[c])
                            drive_d[c] = ~drive_o[c];
                        else
                            drive_d[c] = drive_o[c];
                    end
                    default: drive_d[c] = logic_q[c];
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // boost phase next value
    // ------------------------------------------------------------
    always_comb
    begin
        for (int c = 0; c < NUM_CH; c++)
        begin
            if (!is_boost[c] || !drive_o[c])
                boost_d[c] = 1'b0;
            else if (drive_rise[c])
                boost_d[c] = 1'b1;
            else if (tmr_tick[c])
                boost_d[c] = 1'b0;
            else
                boost_d[c] = boost_q[c];
        end
    end

    // ------------------------------------------------------------
    // state flops
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            logic_q <= '0;
            latch_q <= '0;
            drive_o <= '0;
            boost_q <= '0;
        end
        else
        begin
            logic_q <= logic_d;
            latch_q <= latch_d;
            drive_o <= drive_d;
            boost_q <= boost_d;
        end
    end

    // ------------------------------------------------------------
    // current command and feedback outputs
    // ------------------------------------------------------------
    // current follows the boost phase in the same cycle, one cycle behind drive; on/off type
    // reports zero since its load is switched straight to supply
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            current_cmd_o <= '0;
            output_feedback_value_o <= '0;
        end
        else
        begin
            for (int c = 0; c < NUM_CH; c++)
            begin
                if (is_boost[c] && drive_o[c])
                    current_cmd_o[c] <= boost_d[c] ? boosti_q[c] : holdi_q[c];
                else
                    current_cmd_o[c] <= 16'h0000;
                // only digital types load the drive state here
                output_feedback_value_o[c] <= is_dig[c] & drive_d[c];
            end
        end
    end
endmodule

// ---- common/dvo_pkg.sv ----
/*
 * dvo_pkg: constants shared by the digital valve output logic.
 * assumes a 40 MHz device clock and a plain register port with 32-bit data.
 */
package dvo_pkg;
    // ------------------------------------------------------------
    // clock and time base
    // ------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 40_000_000;   // device clock rate
    localparam int MS_TIME_MS = 1;             // profile time unit, in ms
    localparam int MS_CYCLES = CLK_FREQ_HZ / 1000 * MS_TIME_MS; // cycles per ms
    localparam int NUM_CH = 2;                 // two outputs

    // ------------------------------------------------------------
    // register map, byte addresses; channel 1 sits at +CH_STRIDE
    // ------------------------------------------------------------
    localparam logic [7:0] CH_STRIDE = 8'h40;
    localparam logic [5:0] REG_OTYPE = 6'h00;   // output_type_select
    localparam logic [5:0] REG_CSRC = 6'h04;    // control_source_select
    localparam logic [5:0] REG_POL = 6'h08;     // polarity selection
    localparam logic [5:0] REG_FMODE = 6'h0C;   // fault reaction selection
    localparam logic [5:0] REG_FSTATE = 6'h10;  // fault preset state
    localparam logic [5:0] REG_BUSVAL = 6'h14;  // bus-commanded digital state
    localparam logic [5:0] REG_BOOSTI = 6'h18;  // boost current
    localparam logic [5:0] REG_HOLDI = 6'h1C;   // hold current
    localparam logic [5:0] REG_BOOSTT = 6'h20;  // boost time, ms
    localparam logic [5:0] REG_BLINKT = 6'h24;  // blink period, ms
    localparam logic [5:0] REG_STATUS = 6'h28;  // read-only channel state

    // ------------------------------------------------------------
    // codes
    // ------------------------------------------------------------
    localparam logic [15:0] OTYPE_ONOFF = 16'h03E8;   // 1000
    localparam logic [15:0] OTYPE_BOOST = 16'h03FC;   // 1020
    localparam logic [15:0] OTYPE_RST = 16'h0014;     // 20, proportional current
    localparam logic [7:0] CSRC_UNUSED = 8'h00;
    localparam logic [7:0] CSRC_BUS = 8'h01;
    localparam logic [7:0] CSRC_RST = 8'h01;
    localparam logic [1:0] POL_NORMAL = 2'h0;
    localparam logic [1:0] POL_INVERSE = 2'h1;
    localparam logic [1:0] POL_LATCHED = 2'h2;
    localparam logic [1:0] POL_BLINK = 2'h3;
    localparam logic [1:0] POL_RST = 2'h0;
    localparam logic FMODE_KEEP = 1'b0;
    localparam logic FMODE_PRESET = 1'b1;
    localparam logic FMODE_RST = 1'b1;
    localparam logic FSTATE_RST = 1'b0;
    localparam logic [15:0] BOOSTI_RST = 16'h0000;
    localparam logic [15:0] HOLDI_RST = 16'h0000;
    localparam logic [15:0] BOOSTT_RST = 16'h0064;    // 100 ms
    localparam logic [15:0] BLINKT_RST = 16'h01F4;    // 500 ms
endpackage

// ---- verilog/dvo_rise.sv ----
/*
 * dvo_rise: off-to-on detector for one level.
 * assumes the level is synchronous to mclk_i.
 */
`timescale 1ns/1ps
module dvo_rise
    import dvo_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic rise_o
);
    logic prev_q; // level seen one edge ago

    // --------------------------------------------------------
    // history flop
    // --------------------------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            prev_q <= 1'b0;
        else
            prev_q <= d_i;
    end

    assign rise_o = d_i & ~prev_q; // high for the first cycle of an on level
endmodule

// ---- verilog/dvo_ms_timer.sv ----
/*
 * dvo_ms_timer: millisecond interval timer with restart.
 * assumes restart_i is a one-cycle pulse; a period of 0 acts as 1 ms.
 */
`timescale 1ns/1ps
module dvo_ms_timer
    import dvo_pkg::*;
#(
    parameter int MS_CYC = MS_CYCLES
)
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic restart_i,
    input wire logic [15:0] period_ms_i,
    output logic tick_o
);
    logic [31:0] pre_q; // cycles inside the current millisecond
    logic [15:0] ms_q;  // whole milliseconds elapsed
    logic ms_end;
    logic per_end;

    assign ms_end = (pre_q == 32'(MS_CYC - 1));
    assign per_end = ms_end && ((ms_q + 16'h0001) >= period_ms_i);
    assign tick_o = per_end & ~restart_i;

    // --------------------------------------------------------
    // prescaler and interval count, both cleared on restart
    // --------------------------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pre_q <= 32'h0000_0000;
            ms_q <= 16'h0000;
        end
        else if (restart_i || ms_end)
        begin
            pre_q <= 32'h0000_0000;
            // full interval again after a restart or a finished period
            ms_q <= (restart_i || per_end) ? 16'h0000 : ms_q + 16'h0001;
        end
        else
            pre_q <= pre_q + 32'h0000_0001;
    end
endmodule

// ---- test/dvo_sva.sv ----
/* dvo_sva: port checker for dvo_top.
   assumes a bind from the bench and levels synchronous to mclk_i. */
`timescale 1ns/1ps
module dvo_sva
    import dvo_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic [NUM_CH-1:0] ctrl_fault_i,
    input wire logic [NUM_CH-1:0] enable_ok_i,
    input wire logic [NUM_CH-1:0] enable_fault_i,
    input wire logic [NUM_CH-1:0] override_on_i,
    input wire logic [NUM_CH-1:0] override_fault_i,
    input wire logic [NUM_CH-1:0] drive_o,
    input wire logic [NUM_CH-1:0][15:0] current_cmd_o,
    input wire logic [NUM_CH-1:0] output_feedback_value_o
);
    // ----------------
    // port relations, one clock domain
    // ----------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // no input of output 0 reports an error
    wire logic nf0 = !(ctrl_fault_i[0] || enable_fault_i[0] || override_fault_i[0]);
    a_fb_mirror_zero: assert property (output_feedback_value_o[0] == drive_o[0])
        else $error("feedback differs from drive on output 0");
    a_fb_mirror_one: assert property (output_feedback_value_o[1] == drive_o[1])
        else $error("feedback differs from drive on output 1");
    a_override_forces_off: assert property (nf0 && override_on_i[0] |=> !drive_o[0])
        else $error("override did not force output 0 off");
    a_disable_forces_off: assert property (nf0 && !enable_ok_i[0] |=> !drive_o[0])
        else $error("disable did not force output 0 off");
    a_off_no_current: assert property (!drive_o[0] |=> current_cmd_o[0] == 16'h0000)
        else $error("current left on after drive off");
    // a steady error freezes the drive, whether kept or preset
    a_ctrl_fault_holds: assert property ((ctrl_fault_i[0] && !reg_wr_i)[*2] |=> $stable(drive_o[0]))
        else $error("drive moved under a control error");
    a_en_fault_holds: assert property ((enable_fault_i[0] && !reg_wr_i)[*2] |=> $stable(drive_o[0]))
        else $error("drive moved under an enable error");
    a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
        else $error("read data outside its cycle");
endmodule

// ---- test/dvo_bus_master.sv ----
/* dvo_bus_master: network master model writing and reading objects.
   assumes the device never stalls; reads are checked by the caller. */
`timescale 1ns/1ps
module dvo_bus_master
(
    input wire logic mclk_i,
    output logic [7:0] reg_addr_o,
    output logic [31:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o
);
    // ----------------
    // bus cycles
    // ----------------
    initial
    begin
        reg_addr_o = 8'h80;
        reg_wdata_o = 32'h0000_0000;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end
    // one write cycle; released lines show the inverse
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge mclk_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
    endtask
    // one read strobe; data stands in the cycle after return
    task automatic rd(input logic [7:0] a);
        @(posedge mclk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge mclk_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
    endtask
endmodule

// ---- test/tb_digital_valve_output_logic.sv ----
/* tb_digital_valve_output_logic: self-checking bench for dvo_top.
   assumes a shortened millisecond (10 cycles) and the master model. */
`timescale 1ns/1ps
module tb_digital_valve_output_logic
    import dvo_pkg::*;
;
    // ----------------
    // stimulus and observation signals
    // ----------------
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr;
    logic wr, rd, look = 1'b0, seen = 1'b0;
    logic [31:0] wdata, rdata, got, v;
    logic [1:0][15:0] ctrl_local = '0;
    logic [1:0][15:0] cur;
    logic [1:0] eok = 2'h3;
    logic [1:0] cflt = 2'h0, eflt = 2'h0, ovr = 2'h0, oflt = 2'h0;
    logic [1:0] drive, sel = 2'h0;
    logic [31:0] exp_q[$];
    int bad_count = 0, n_compared = 0, seed = 98080, cyc = 0;
    always #12.5 mclk_i = ~mclk_i;
    dvo_top #(.MS_CYC(10)) dvo_top_i (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .ctrl_local_i(ctrl_local), .ctrl_fault_i(cflt), .enable_ok_i(eok),
        .enable_fault_i(eflt), .override_on_i(ovr), .override_fault_i(oflt),
        .drive_o(drive), .current_cmd_o(cur), .output_feedback_value_o());
    dvo_bus_master dvo_bus_master_i (.mclk_i(mclk_i), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
    // ----------------
    // tasks
    // ----------------
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // queue an expectation, checked at the next edge
    task automatic note(input logic [1:0] s, input logic [31:0] e);
        exp_q.push_back(e);
        sel <= s;
        look <= ~look;
        @(posedge mclk_i);
    endtask
    task automatic wreg(input logic ch, input logic [5:0] off, input logic [31:0] d);
        dvo_bus_master_i.wr({1'b0, ch, off}, d);
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        dvo_bus_master_i.rd(a);
        note(2'h2, e);
    endtask
    // command a bus state, then check the settled drive
    task automatic bus_on(input logic ch, input logic [31:0] d, input logic e);
        wreg(ch, REG_BUSVAL, d);
        repeat (3) @(posedge mclk_i);
        note({1'b0, ch}, 32'(e));
    endtask
    task automatic setf(input int k, input logic f);
        case (k)
            0: cflt[0] <= f;
            1: eflt[0] <= f;
            default: oflt[0] <= f;
        endcase
        repeat (3) @(posedge mclk_i);
    endtask
    // ----------------
    // monitor: oldest note against the output
    // ----------------
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            test_done();
        end
        else if (look !== seen)
        begin
            seen = look;
            case (sel)
                2'h0, 2'h1: got = {31'h0000_0000, drive[sel[0]]};
                2'h2: got = rdata;
                default: got = {16'h0000, cur[0]};
            endcase
            n_compared++;
            if (got !== exp_q[0])
            begin
                bad_count++;
                $display("mismatch at %0t: sel %0d got %h want %h", $time, sel, got, exp_q[0]);
            end
            void'(exp_q.pop_front());
        end
    end
    // ----------------
    // main sequence
    // ----------------
    initial
    begin
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
        rreg(8'h00, 32'(OTYPE_RST));
        rreg(8'h44, 32'h0000_0001);
        rreg(8'h48, 32'h0000_0000);
        rreg(8'h0C, 32'h0000_0001);
        rreg(8'h80, 32'h0000_0000);
        bus_on(1'b0, 32'h0000_0001, 1'b0);
        bus_on(1'b0, 32'h0000_0000, 1'b0);
        wreg(1'b0, REG_OTYPE, 32'(OTYPE_ONOFF));
        wreg(1'b0, REG_POL, 32'(POL_LATCHED));
        for (int i = 0; i < 5; i++)
            bus_on(1'b0, {31'h0000_0000, ~i[0]}, 1'(5'b10011 >> i));
        for (int p = 0; p < 2; p++)
        begin
            wreg(1'b0, REG_POL, 32'(p));
            for (int i = 0; i < 4; i++)
            begin
                v = $random(seed) & 32'h0000_0003;
                bus_on(1'b0, v, (v != 32'h0000_0000) ^ p[0]);
            end
        end
        // blink at 1 ms: on, off, on, sampled mid-interval
        bus_on(1'b0, 32'h0000_0000, 1'b1);
        wreg(1'b0, REG_POL, 32'h0000_0000);
        wreg(1'b0, REG_BLINKT, 32'h0000_0001);
        wreg(1'b0, REG_POL, 32'(POL_BLINK));
        wreg(1'b0, REG_BUSVAL, 32'h0000_0001);
        repeat (7) @(posedge mclk_i);
        for (int i = 0; i < 3; i++)
        begin
            note(2'h0, {31'h0000_0000, ~i[0]});
            repeat (9) @(posedge mclk_i);
        end
        // boost for 2 ms then hold; blink must act as plain on/off
        bus_on(1'b0, 32'h0000_0000, 1'b0);
        wreg(1'b0, REG_OTYPE, 32'(OTYPE_BOOST));
        wreg(1'b0, REG_BOOSTI, 32'h0000_0123);
        wreg(1'b0, REG_HOLDI, 32'h0000_0045);
        wreg(1'b0, REG_BOOSTT, 32'h0000_0002);
        wreg(1'b0, REG_BUSVAL, 32'h0000_0001);
        repeat (5) @(posedge mclk_i);
        note(2'h3, 32'h0000_0123);
        repeat (21) @(posedge mclk_i);
        note(2'h3, 32'h0000_0045);
        note(2'h0, 32'h0000_0001);
        bus_on(1'b0, 32'h0000_0000, 1'b0);
        note(2'h3, 32'h0000_0000);
        // each error source under keep and preset-off
        wreg(1'b0, REG_OTYPE, 32'(OTYPE_ONOFF));
        wreg(1'b0, REG_POL, 32'h0000_0000);
        bus_on(1'b0, 32'h0000_0001, 1'b1);
        for (int k = 0; k < 3; k++)
            for (int m = 0; m < 2; m++)
            begin
                wreg(1'b0, REG_FMODE, 32'(m));
                setf(k, 1'b1);
                note(2'h0, {31'h0000_0000, ~m[0]});
                setf(k, 1'b0);
            end
        ovr[0] <= 1'b1;
        bus_on(1'b0, 32'h0000_0001, 1'b0);
        ovr[0] <= 1'b0;
        eok[0] <= 1'b0;
        bus_on(1'b0, 32'h0000_0001, 1'b0);
        eok[0] <= 1'b1;
        bus_on(1'b0, 32'h0000_0001, 1'b1);
        // output 1 from local control; output 0 must ignore it
        wreg(1'b1, REG_OTYPE, 32'(OTYPE_ONOFF));
        wreg(1'b1, REG_CSRC, 32'h0000_0002);
        for (int i = 0; i < 6; i++)
        begin
            v = $random(seed) & 32'h0000_0003;
            ctrl_local[1] <= v[15:0];
            repeat (3) @(posedge mclk_i);
            note(2'h1, 32'(v != 32'h0000_0000));
            note(2'h0, 32'h0000_0001);
        end
        test_done();
    end
endmodule
bind dvo_top dvo_sva dvo_sva_i (.mclk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .ctrl_fault_i, .enable_ok_i, .enable_fault_i, .override_on_i, .override_fault_i,
    .drive_o, .current_cmd_o, .output_feedback_value_o);
